// ### nv_sram_rtc_core.sv
// Byte-wide static RAM with a BCD clock in its top eight bytes.
// Assumes asynchronous SRAM strobes from a host, a 100 MHz clk and a
// power-fail level from an outside comparator.
//
// Contract
// R1: Seconds bit 7 stops the oscillator.
// R2: Oscillator stop write accepted any time.
// R3: Weekday bit 6 toggles seconds LSB at 512Hz.
// R4: Seconds read shows toggling data_bit_zero.
// R5: Host writes zero to unused bits.
// R6: Read whenever select low, write high.
// R7: Read data valid after latest access delay.
// R8: Drive data only with select and output enable.
// R9: Address change: hold, then undefined data.
// R10: Write while select and write strobe low.
// R11: Host holds address through write.
// R12: Host observes write recovery between cycles.
// R13: Host meets data setup and hold.
// R14: Write strobe falling releases driven read data.
// R15: Power fail blocks all access.
// R16: Power fail drives power_fail_out_n low.
// R17: Write bit freezes, clearing loads counters.
// R18: Read bit freezes view; counting continues.
// R19: BCD fields in 24-hour format.
// R20: Month lengths and leap years handled.
// R21: Seconds advance each second, fields roll over.
`timescale 1ns/1ps
`default_nettype none

module nv_sram_rtc_core #(
  parameter int unsigned ADDR_W = nv_rtc_pkg::ADDR_W,
  parameter int unsigned TICK_CYC = nv_rtc_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic sel_n,
  input wire logic out_en_n,
  input wire logic wr_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic power_fail,
  output logic power_fail_out_n,
  output logic power_fail_oe
);

  // BCD increment with wrap to a given low value past the limit
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] lim,
                                          input logic [7:0] low);
    logic [7:0] r;
    r = v;
    if (v >= lim)
      r = low;
    else if (v[3:0] == 4'h9)
      r = {v[7:4] + 4'h1, nv_rtc_pkg::ZERO_NIBBLE};
    else
      r = {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction

  // Last day of a month, in BCD; year divisible by four is leap (00-99)
  function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = (yr[4] == 1'b0) ? (yr[1:0] == 2'b00) : (yr[1:0] == 2'b10);
    case (mon)
      8'h02: month_last = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  endfunction

  // Two-flop synchronisers for pins
  nv_rtc_pkg::strobe_t strobe_meta;
  nv_rtc_pkg::strobe_t strobe_sync;
  logic [ADDR_W-1:0] addr_meta;
  logic [ADDR_W-1:0] addr_sync;
  logic [7:0] din_meta;
  logic [7:0] din_sync;
  logic pf_meta;
  logic pf_sync;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      strobe_meta <= '1;
      strobe_sync <= '1;
      pf_meta <= 1'b0;
      pf_sync <= 1'b0;
    end
    else
    begin
      strobe_meta <= {sel_n, out_en_n, wr_n};
      strobe_sync <= strobe_meta;
      pf_meta <= power_fail;
      pf_sync <= pf_meta;
    end
  end

  // Address and data carry no control meaning; no reset needed
  always_ff @(posedge clk)
  begin
    addr_meta <= addr;
    addr_sync <= addr_meta;
    din_meta <= data_in;
    din_sync <= din_meta;
  end

  // Power fail forces select inactive internally
  logic sel_eff;
  logic rd_eff;
  logic wr_eff;
  assign sel_eff = !strobe_sync.sel_n && !pf_sync; // [R15]
  assign wr_eff = sel_eff && !strobe_sync.wr_n; // [R10]
  assign rd_eff = sel_eff && strobe_sync.wr_n; // [R6]

  // Memory array below the clock bytes
  logic [7:0] mem [0:(1 << ADDR_W) - 1];
  logic is_clock;
  logic [2:0] reg_idx;
  assign is_clock = (addr_sync[ADDR_W-1:3] == {(ADDR_W-3){1'b1}});
  assign reg_idx = addr_sync[2:0];

  // Divider: one enable per half period of the test tone
  logic [$clog2(TICK_CYC)-1:0] div_cnt;
  logic tick;
  logic [9:0] tick_cnt;
  logic osc_stop;
  logic second_tick;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_cnt <= '0;
      tick <= 1'b0;
      tick_cnt <= '0;
    end
    else if (osc_stop)
    begin
      tick <= 1'b0; // [R1]
    end
    else
    begin
      tick <= (div_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1));
      div_cnt <= (div_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1)) ? '0 : div_cnt + 1'b1;
      if (tick)
        tick_cnt <= tick_cnt + 10'h001;
    end
  end
  assign second_tick = tick && (tick_cnt == 10'h3ff); // [R21]

  // Halt bits, frequency test and stop bit
  logic write_halt;
  logic read_halt;
  logic freq_test;
  logic test_phase;
  logic write_halt_d;
  logic read_halt_d;
  logic wr_eff_d;
  logic wr_commit;
  assign wr_commit = wr_eff && !wr_eff_d; // Write begins at later falling edge [R10]

  // Running counters and the host-visible copy
  nv_rtc_pkg::time_t run;
  nv_rtc_pkg::time_t view;
  nv_rtc_pkg::time_t next_run;

  // Calendar advance with rollover at each field's limit
  always_comb
  begin
    next_run = run;
    next_run.seconds = bcd_step(run.seconds, 8'h59, 8'h00); // [R19] [R21]
    if (run.seconds == 8'h59)
    begin
      next_run.minutes = bcd_step(run.minutes, 8'h59, 8'h00);
      if (run.minutes == 8'h59)
      begin
        next_run.hours = bcd_step(run.hours, 8'h23, 8'h00); // 24-hour [R19]
        if (run.hours == 8'h23)
        begin
          next_run.weekday = bcd_step(run.weekday, 8'h07, 8'h01);
          next_run.date = bcd_step(run.date, month_last(run.month, run.year), 8'h01); // [R20]
          if (run.date >= month_last(run.month, run.year))
          begin
            next_run.month = bcd_step(run.month, 8'h12, 8'h01);
            if (run.month == 8'h12)
              next_run.year = bcd_step(run.year, 8'h99, 8'h00);
          end
        end
      end
    end
  end

  // Control bits: any write lands at once, no precondition
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      write_halt <= 1'b0;
      read_halt <= 1'b0;
      freq_test <= 1'b0;
      osc_stop <= 1'b0;
      wr_eff_d <= 1'b0;
      write_halt_d <= 1'b0;
      read_halt_d <= 1'b0;
    end
    else
    begin
      wr_eff_d <= wr_eff;
      write_halt_d <= write_halt;
      read_halt_d <= read_halt;
      if (wr_commit && is_clock)
      begin
        if (reg_idx == nv_rtc_pkg::CONTROL_HALT_BITS[2:0])
        begin
          write_halt <= din_sync[nv_rtc_pkg::WRITE_HALT_BIT]; // [R17]
          read_halt <= din_sync[nv_rtc_pkg::READ_HALT_BIT]; // [R18]
        end
        if (reg_idx == nv_rtc_pkg::SECONDS_AND_OSC_STOP[2:0])
          osc_stop <= din_sync[nv_rtc_pkg::OSC_STOP_BIT]; // [R1] [R2]
        if (reg_idx == nv_rtc_pkg::WEEKDAY_AND_TEST[2:0])
          freq_test <= din_sync[nv_rtc_pkg::FREQ_TEST_BIT]; // [R3]
      end
    end
  end

  // Running counters keep counting under the read halt
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      run <= '{year: nv_rtc_pkg::ZERO_BYTE, month: nv_rtc_pkg::CALENDAR_ONE,
               date: nv_rtc_pkg::CALENDAR_ONE, weekday: nv_rtc_pkg::CALENDAR_ONE,
               hours: nv_rtc_pkg::ZERO_BYTE, minutes: nv_rtc_pkg::ZERO_BYTE,
               seconds: nv_rtc_pkg::SECONDS_RESET};
    end
    else if (write_halt_d && !write_halt)
      run <= view; // Loaded values go to the counters [R17]
    else if (second_tick && !write_halt)
      run <= next_run; // [R18] [R21]
  end

  // Visible copy: frozen under either halt, loadable under write halt
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      view <= '{year: nv_rtc_pkg::ZERO_BYTE, month: nv_rtc_pkg::CALENDAR_ONE,
                date: nv_rtc_pkg::CALENDAR_ONE, weekday: nv_rtc_pkg::CALENDAR_ONE,
                hours: nv_rtc_pkg::ZERO_BYTE, minutes: nv_rtc_pkg::ZERO_BYTE,
                seconds: nv_rtc_pkg::SECONDS_RESET};
    else if (write_halt && wr_commit && is_clock)
    begin
      // Stored as written except seconds bit 7 and weekday bits 7:6, which load zero; other unused bits rely on the host writing zero [R5]
      case (reg_idx)
        3'h1: view.seconds <= {1'b0, din_sync[6:0]};
        3'h2: view.minutes <= din_sync;
        3'h3: view.hours <= din_sync;
        3'h4: view.weekday <= {1'b0, 1'b0, din_sync[5:0]};
        3'h5: view.date <= din_sync;
        3'h6: view.month <= din_sync;
        3'h7: view.year <= din_sync;
        default: view <= view;
      endcase
    end
    else if (!write_halt && !read_halt && !read_halt_d)
      view <= run; // Refreshes two cycles after the read bit clears [R18]
  end

  // Test tone: toggles on each half-period enable while the oscillator runs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      test_phase <= 1'b0;
    else if (!freq_test)
      test_phase <= 1'b0;
    else if (tick)
      test_phase <= ~test_phase; // [R3]
  end

  // Plain RAM writes
  always_ff @(posedge clk)
  begin
    if (wr_commit && !is_clock)
      mem[addr_sync] <= din_sync; // [R10]
  end

  // Read mux for the addressed byte
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = mem[addr_sync];
    if (is_clock)
    begin
      case (reg_idx)
        3'h0: rd_byte = {write_halt, read_halt, 6'h00};
        3'h1: rd_byte = {osc_stop, view.seconds[6:1], view.seconds[0] ^ test_phase}; // [R4]
        3'h2: rd_byte = view.minutes;
        3'h3: rd_byte = view.hours;
        3'h4: rd_byte = {1'b0, freq_test, view.weekday[5:0]};
        3'h5: rd_byte = view.date;
        3'h6: rd_byte = view.month;
        3'h7: rd_byte = view.year;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Access timing: count cycles since address, select and output enable
  localparam int unsigned ACC_W_L = nv_rtc_pkg::ACC_W;
  logic [ACC_W_L-1:0] addr_age;
  logic [ACC_W_L-1:0] sel_age;
  logic [ACC_W_L-1:0] oe_age;
  logic [ACC_W_L-1:0] we_age;
  logic [ADDR_W-1:0] addr_prev;
  logic [7:0] held;
  logic drive_window;
  logic data_ready;
  logic hold_ok;
  assign drive_window = rd_eff && !strobe_sync.out_en_n; // [R8]
  // Age counter lags an address change by a cycle, so compare directly too
  assign data_ready = (addr_sync == addr_prev) &&
                      (addr_age >= ACC_W_L'(nv_rtc_pkg::ADDRESS_ACCESS_CYC)) &&
                      (sel_age >= ACC_W_L'(nv_rtc_pkg::SELECT_ACCESS_CYC)) &&
                      (oe_age >= ACC_W_L'(nv_rtc_pkg::OUTPUT_ACCESS_CYC)); // [R7]
  assign hold_ok = (addr_sync != addr_prev) ||
                   (addr_age < ACC_W_L'(nv_rtc_pkg::OUTPUT_HOLD_CYC)); // [R9]

  // Saturating age counters
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      addr_age <= '0;
      sel_age <= '0;
      oe_age <= '0;
      we_age <= '0;
      addr_prev <= '0;
    end
    else
    begin
      addr_prev <= addr_sync;
      addr_age <= (addr_sync != addr_prev) ? '0 : (&addr_age ? addr_age : addr_age + 1'b1);
      sel_age <= !sel_eff ? '0 : (&sel_age ? sel_age : sel_age + 1'b1);
      oe_age <= strobe_sync.out_en_n ? '0 : (&oe_age ? oe_age : oe_age + 1'b1);
      we_age <= !wr_eff ? '0 : (&we_age ? we_age : we_age + 1'b1);
    end
  end

  // Output pins: undefined stand-in is all ones until access completes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      held <= 8'h00;
    end
    else
    begin
      data_oe <= drive_window ||
                 (wr_eff && !strobe_sync.out_en_n &&
                  we_age < ACC_W_L'(nv_rtc_pkg::WRITE_RELEASE_CYC)); // [R14]
      if (data_ready)
      begin
        data_out <= rd_byte;
        held <= rd_byte;
      end
      else if (hold_ok && addr_age != sel_age)
        data_out <= held; // [R9]
      else
        data_out <= 8'hff; // [R8] [R9]
    end
  end

  // Open-drain power-fail pin follows the synced level
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      power_fail_out_n <= 1'b0;
      power_fail_oe <= 1'b0;
    end
    else
    begin
      power_fail_out_n <= 1'b0;
      power_fail_oe <= pf_sync; // [R16]
    end
  end

endmodule // nv_sram_rtc_core
`default_nettype wire

// ### nv_rtc_pkg.sv
// Package for the nonvolatile RAM clock core: register map, field positions,
// strobe carriers and timing constants.
// Assumes a 100 MHz system clock and a 19-bit byte address.
package nv_rtc_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Address and data widths of the byte-wide memory
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned DATA_W = 8;

  // Register offsets in the top eight bytes
  localparam logic [18:0] CONTROL_HALT_BITS = 19'h7fff8;
  localparam logic [18:0] SECONDS_AND_OSC_STOP = 19'h7fff9;
  localparam logic [18:0] MINUTES_COUNT = 19'h7fffa;
  localparam logic [18:0] HOURS_COUNT = 19'h7fffb;
  localparam logic [18:0] WEEKDAY_AND_TEST = 19'h7fffc;
  localparam logic [18:0] DAY_OF_MONTH = 19'h7fffd;
  localparam logic [18:0] MONTH_COUNT = 19'h7fffe;
  localparam logic [18:0] YEAR_COUNT = 19'h7ffff;
  localparam logic [2:0] CLOCK_BASE_HI = 3'h7;

  // Field positions
  localparam int unsigned OSC_STOP_BIT = 7;
  localparam int unsigned FREQ_TEST_BIT = 6;
  localparam int unsigned WRITE_HALT_BIT = 7;
  localparam int unsigned READ_HALT_BIT = 6;

  // Values after reset
  localparam logic [7:0] SECONDS_RESET = 8'h00;
  localparam logic [7:0] CALENDAR_ONE = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] ZERO_NIBBLE = 4'h0;

  // Timing figures as printed, in ns, and derived cycle counts
  localparam int unsigned ADDRESS_ACCESS_DELAY_NS = 120;
  localparam int unsigned SELECT_ACCESS_DELAY_NS = 120;
  localparam int unsigned OUTPUT_ACCESS_DELAY_NS = 100;
  localparam int unsigned OUTPUT_HOLD_INTERVAL_NS = 5;
  localparam int unsigned WRITE_RELEASE_DELAY_NS = 40;
  // Longest times round down, least times round up, none under one cycle
  localparam int unsigned ADDRESS_ACCESS_CYC = ADDRESS_ACCESS_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned SELECT_ACCESS_CYC = SELECT_ACCESS_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned OUTPUT_ACCESS_CYC = OUTPUT_ACCESS_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned OUTPUT_HOLD_CYC =
    (OUTPUT_HOLD_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_RELEASE_CYC =
    (WRITE_RELEASE_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : WRITE_RELEASE_DELAY_NS / CLK_PERIOD_NS;

  // Oscillator rates
  localparam int unsigned TEST_HZ = 512;
  localparam int unsigned TEST_HALF_HZ = 2 * TEST_HZ;
  localparam int unsigned TICK_CYC = CLK_HZ / TEST_HALF_HZ;
  localparam int unsigned TICKS_PER_SECOND = TEST_HALF_HZ;

  // Access counter width
  localparam int unsigned ACC_W = 5;

  // Strobes as sampled from the pins
  typedef struct packed {
    logic sel_n;
    logic out_en_n;
    logic wr_n;
  } strobe_t;

  // Timekeeping fields, all BCD
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] weekday;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } time_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_READ = 2'b01,
    BUS_WRITE = 2'b10
  } bus_state_t;

endpackage

// ### nv_rtc_props.sv
// Concurrent checks on the clock core pins, bound into every core.
// Assumes two sync flops on inputs and registered outputs (3 edges).
`timescale 1ns/1ps
`default_nettype none
module nv_rtc_props #(
  parameter int unsigned ADDR_W = 19,
  parameter int unsigned TICK_CYC = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic sel_n,
  input wire logic out_en_n,
  input wire logic wr_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic power_fail,
  input wire logic power_fail_out_n,
  input wire logic power_fail_oe
);
  // Every answer lags its cause by the sync chain plus one register
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_oe_needs_access;
    data_oe |-> $past(!sel_n && !out_en_n, 3);
  endproperty
  a_oe_needs_access: assert property (p_oe_needs_access)
    else $error("data driven without select and output enable");
  property p_pf_blocks_read;
    $past(power_fail, 3) |-> !data_oe;
  endproperty
  a_pf_blocks_read: assert property (p_pf_blocks_read)
    else $error("data driven during power fail");
  property p_pf_pin_low;
    $past(power_fail, 3) |-> power_fail_oe && !power_fail_out_n;
  endproperty
  a_pf_pin_low: assert property (p_pf_pin_low)
    else $error("power fail pin not pulled low");
  property p_pf_pin_release;
    !$past(power_fail, 3) |-> !power_fail_oe;
  endproperty
  a_pf_pin_release: assert property (p_pf_pin_release)
    else $error("power fail pin held after supply returned");
  property p_read_drives;
    (!sel_n && !out_en_n && wr_n && !power_fail) [*4] |-> data_oe;
  endproperty
  a_read_drives: assert property (p_read_drives)
    else $error("read access not driving data");
  property p_write_releases;
    $fell(wr_n) && !sel_n && !out_en_n |-> ##[1:10] !data_oe;
  endproperty
  a_write_releases: assert property (p_write_releases)
    else $error("bus not released after write strobe");
  property p_write_quiet;
    (!sel_n && !wr_n) [*8] |-> ##2 !data_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("data driven during sustained write");
  property p_ripple_undefined;
    !$stable(addr) && !sel_n && !out_en_n && wr_n && data_oe
      |-> ##5 (data_out == 8'hff) [*5];
  endproperty
  a_ripple_undefined: assert property (p_ripple_undefined)
    else $error("data not undefined after address change");
endmodule // nv_rtc_props
bind nv_sram_rtc_core nv_rtc_props #(.ADDR_W(ADDR_W), .TICK_CYC(TICK_CYC)) props (
  .clk, .rst_n, .addr, .sel_n, .out_en_n, .wr_n, .data_in, .data_out, .data_oe,
  .power_fail, .power_fail_out_n, .power_fail_oe
);
`default_nettype wire

// ### tb_host.sv
// Host model driving the core's SRAM-style strobes and data wire.
// Assumes all changes on falling edges of clk.
`timescale 1ns/1ps
`default_nettype none
module tb_host (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic [18:0] addr,
  output logic sel_n,
  output logic out_en_n,
  output logic wr_n,
  output logic [7:0] data_in
);
  logic drv = 1'b0;
  logic [7:0] wd = 8'h00;
  // Undriven wire shows inverted last value, never a stale copy
  assign data_in = data_oe ? data_out : (drv ? wd : ~wd);
  initial
  begin
    addr = 19'h00000;
    sel_n = 1'b1;
    out_en_n = 1'b1;
    wr_n = 1'b1;
  end
  // Strobes inactive long enough to part two cycles
  task automatic idle();
    @(negedge clk);
    sel_n = 1'b1;
    out_en_n = 1'b1;
    wr_n = 1'b1;
    drv = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // Strobes left low, so the next read ripples through
  task automatic rd(input logic [18:0] a, output logic [7:0] d, output logic oe);
    @(negedge clk);
    addr = a;
    sel_n = 1'b0;
    out_en_n = 1'b0;
    repeat (22) @(negedge clk);
    d = data_out;
    oe = data_oe;
  endtask
  task automatic wr(input logic [18:0] a, input logic [7:0] d, input logic oe,
                    output logic rel);
    int n;
    idle();
    addr = a;
    sel_n = 1'b0;
    out_en_n = !oe;
    if (oe)
      repeat (18) @(negedge clk);
    @(negedge clk);
    wr_n = 1'b0;
    drv = 1'b1;
    wd = d;
    n = 0;
    // Device owns the wire until it lets go
    while (data_oe && n < 12)
    begin
      @(negedge clk);
      n++;
    end
    rel = !data_oe;
    repeat (8) @(negedge clk);
    wr_n = 1'b1;
    repeat (3) @(negedge clk);
    idle();
  endtask
endmodule // tb_host
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the clock core: register table, then
// calendar, oscillator, test tone, power fail and reset cases.
// Assumes the host model owns all strobes; TICK_CYC is cut to 4.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [18:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic power_fail = 1'b0;
  logic [18:0] addr;
  logic sel_n;
  logic out_en_n;
  logic wr_n;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic data_oe;
  logic power_fail_out_n;
  logic power_fail_oe;
  logic pf_pin;
  logic [7:0] got;
  logic oe;
  logic rel;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int tog;
  logic [7:0] s0;
  // Write halt first, so loaded bytes read back as written
  row_t rows [8] = '{'{nv_rtc_pkg::CONTROL_HALT_BITS, 8'h80, 8'h80},
    '{19'h00000, 8'ha5, 8'ha5}, '{19'h7fff7, 8'h3c, 8'h3c},
    '{nv_rtc_pkg::YEAR_COUNT, 8'h99, 8'h99}, '{nv_rtc_pkg::MONTH_COUNT, 8'h12, 8'h12},
    '{nv_rtc_pkg::DAY_OF_MONTH, 8'h31, 8'h31}, '{nv_rtc_pkg::HOURS_COUNT, 8'h23, 8'h23},
    '{nv_rtc_pkg::MINUTES_COUNT, 8'h59, 8'h59}};
  // Last second of 28 February, leap year, and the time one second on
  row_t leap [7] = '{'{nv_rtc_pkg::YEAR_COUNT, 8'h04, 8'h04},
    '{nv_rtc_pkg::MONTH_COUNT, 8'h02, 8'h02}, '{nv_rtc_pkg::DAY_OF_MONTH, 8'h28, 8'h29},
    '{nv_rtc_pkg::HOURS_COUNT, 8'h23, 8'h00}, '{nv_rtc_pkg::MINUTES_COUNT, 8'h59, 8'h00},
    '{nv_rtc_pkg::SECONDS_AND_OSC_STOP, 8'h59, 8'h00},
    '{nv_rtc_pkg::CONTROL_HALT_BITS, 8'h00, 8'h00}};
  nv_sram_rtc_core #(.ADDR_W(19), .TICK_CYC(4)) dut (
    .clk, .rst_n, .addr, .sel_n, .out_en_n, .wr_n, .data_in, .data_out, .data_oe,
    .power_fail, .power_fail_out_n, .power_fail_oe
  );
  tb_host host (.clk, .data_out, .data_oe, .addr, .sel_n, .out_en_n, .wr_n, .data_in);
  // Pull-up on the open-drain power-fail pin
  assign pf_pin = power_fail_oe ? power_fail_out_n : 1'b1;
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic w(input logic [18:0] a, input logic [7:0] d);
    host.wr(a, d, 1'b0, rel);
  endtask
  task automatic r(input logic [18:0] a);
    host.rd(a, got, oe);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Cuts a hang short; the whole run needs about 14200 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      test_done();
    end
  end
  initial
  begin
    // Three edges so the sync flops settle too
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("oe after reset", 8'h00, {7'h00, data_oe});
    for (int i = 0; i < 8; i++)
      w(rows[i].a, rows[i].d);
    for (int i = 0; i < 8; i++)
    begin
      r(rows[i].a);
      chk("readback", rows[i].e, got);
    end
    for (int i = 0; i < 7; i++)
      w(leap[i].a, leap[i].d);
    repeat (4600) @(negedge clk);
    for (int i = 0; i < 5; i++)
    begin
      r(leap[i].a);
      chk("rollover", leap[i].e, got);
    end
    // Read halt: view frozen over a full second, then refreshed
    w(nv_rtc_pkg::CONTROL_HALT_BITS, 8'h40);
    r(nv_rtc_pkg::SECONDS_AND_OSC_STOP);
    s0 = got;
    repeat (4200) @(negedge clk);
    r(nv_rtc_pkg::SECONDS_AND_OSC_STOP);
    chk("read halt frozen", s0, got);
    w(nv_rtc_pkg::CONTROL_HALT_BITS, 8'h00);
    r(nv_rtc_pkg::SECONDS_AND_OSC_STOP);
    chk("read halt resumed", 8'h01, 8'(got != s0));
    // Stopped oscillator: seconds hold still with the stop bit shown
    w(nv_rtc_pkg::SECONDS_AND_OSC_STOP, 8'h80);
    r(nv_rtc_pkg::SECONDS_AND_OSC_STOP);
    s0 = got;
    repeat (4200) @(negedge clk);
    r(nv_rtc_pkg::SECONDS_AND_OSC_STOP);
    chk("osc stopped", s0, got);
    chk("osc bit", 8'h80, got & 8'h80);
    w(nv_rtc_pkg::SECONDS_AND_OSC_STOP, 8'h00);
    w(nv_rtc_pkg::WEEKDAY_AND_TEST, 8'h41);
    r(nv_rtc_pkg::SECONDS_AND_OSC_STOP);
    tog = 0;
    repeat (32)
    begin
      @(negedge clk);
      tog += int'(data_out[0] !== got[0]);
      got = data_out;
    end
    chk("test tone", 8'h01, 8'(tog > 3));
    w(nv_rtc_pkg::WEEKDAY_AND_TEST, 8'h01);
    power_fail = 1'b1;
    repeat (5) @(negedge clk);
    chk("pf pin", 8'h00, {7'h00, pf_pin});
    w(19'h00000, 8'h5a);
    r(19'h00000);
    chk("pf read", 8'h00, {7'h00, oe});
    power_fail = 1'b0;
    host.idle();
    chk("pf pin freed", 8'h01, {7'h00, pf_pin});
    r(19'h00000);
    chk("pf write", 8'ha5, got);
    host.wr(19'h00001, 8'h11, 1'b1, rel);
    chk("release", 8'h01, {7'h00, rel});
    // Second reset in mid-run restores the calendar start
    host.idle();
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      r(nv_rtc_pkg::YEAR_COUNT - 19'(i));
      chk("reset time", (i == 0) ? 8'h00 : 8'h01, got);
    end
    test_done();
  end
endmodule // tb_top
`default_nettype wire
